// ===== rtl/dps_sequencer.sv
// Contract
// - Same-direction page accesses start at least four internal periods apart.
// - Mixed read/write page accesses keep at least a 3.5 period cycle.
// - Column strobe stays asserted at least two periods per access.
// - Column strobe stays high at least 1.5 periods between pulses.
// - Column address is valid one period before column strobe asserts.
// - Column address holds 2.5 periods after column strobe asserts.
// - Row strobe holds 2.5 periods after the last column strobe assertion.
// - Row strobe holds 4.5 periods after the previous column strobe release.
// - Out-of-page field 10/11 sets 4.75/6.75 period precharge gap; else none.
// - Write strobe asserts 1.25 periods before column strobe on writes.
// - Write strobe stays asserted at least 3.5 periods on writes.
// - Write strobe spans 2.25 after column assert and 3.25 before release.
// - Write data valid 0.5 before column strobe, held 2.5 after.
// - Reads: write strobe off 1.25 before column strobe, 0.75 after release.
// - Read strobe always releases after the column strobe.
// - Wait-state count and refresh period come from control configuration; the code supports only 3 wait states and sets cfg_bad otherwise.
// - Row strobe holds 3.5 periods after the last read strobe assertion.
// - Row strobe holds 3.75 periods after the last write strobe assertion.
// - Last column address valid four periods before row strobe release.
// - Data bus driven 0.75 after write strobe, released within 0.25 of release.
`timescale 1ns/1ns
module dps_sequencer
  import dps_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic [3:0]           cfg_page_wait_states,
  input  wire logic [REFRESH_W-1:0] cfg_refresh_period,
  input  wire logic [1:0]           out_of_page_wait_select,
  input  wire logic                 page_close_req,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic                 req_write,
  input  wire logic [ADDR_W-1:0]    req_row,
  input  wire logic [ADDR_W-1:0]    req_col,
  input  wire logic [DATA_W-1:0]    req_wdata,
  output logic                      rsp_valid,
  output logic [DATA_W-1:0]         rsp_rdata,
  output logic                      cfg_bad,
  output logic                      refresh_due,
  output logic                      dram_ras_n,
  output logic                      dram_cas_n,
  output logic                      dram_rd_n,
  output logic                      dram_wr_n,
  output logic [ADDR_W-1:0]         dram_addr,
  output logic [DATA_W-1:0]         dram_dq_o,
  output logic                      dram_dq_oe,
  input  wire logic [DATA_W-1:0]    dram_dq_i
);

  dps_state_e        state_r;
  dps_state_e        state_nxt;
  logic [PH_W-1:0]   ph_r;
  logic [PH_W-1:0]   ph_nxt;
  logic              acc_start;
  logic              take;
  logic              hit;
  logic              cfg_ok;
  logic              pend_r;
  logic [ADDR_W-1:0] row_r;
  logic [ADDR_W-1:0] cur_row_r;
  logic [ADDR_W-1:0] cur_col_r;
  logic [DATA_W-1:0] cur_wdata_r;
  logic              cur_write_r;
  logic              src_write;
  logic [ADDR_W-1:0] src_col;
  logic [DATA_W-1:0] src_wdata;
  logic              cas_release;
  logic              hold_done;
  logic              gap_done;
  logic [TMR_W-1:0]  gap_val;
  logic              refresh_tick;
  logic              req_ready_r;
  logic              rsp_valid_r;
  logic [DATA_W-1:0] rsp_rdata_r;
  logic              cfg_bad_r;
  logic              refresh_due_r;
  logic              ras_n_r;
  logic              cas_n_r;
  logic              rd_n_r;
  logic              wr_n_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] dq_o_r;
  logic              dq_oe_r;

  assign cfg_ok = (cfg_page_wait_states == SUPPORTED_WS);
  assign take   = req_valid && req_ready_r;
  assign hit    = (req_row == row_r);

  // A column access starting on the accepting edge takes the request directly
  assign src_write = take ? req_write : cur_write_r;
  assign src_col   = take ? req_col   : cur_col_r;
  assign src_wdata = take ? req_wdata : cur_wdata_r;

  assign cas_release = (state_r == ST_ACCESS) && (ph_r == PH_W'(CAS_OFF_Q));

  always_comb begin
    unique case (out_of_page_wait_select)
      OOP_WAIT_A: gap_val = TMR_W'(GAP_A_Q);
      OOP_WAIT_B: gap_val = TMR_W'(GAP_B_Q);
      default:    gap_val = '0;
    endcase
  end

  // Row strobe hold from column release covers the column, read, write
  // and address hold requirements, all of which end earlier
  dps_down_timer u_ras_hold (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .load     (cas_release),
    .load_val (TMR_W'(RAS_HOLD_Q)),
    .done     (hold_done)
  );

  dps_down_timer u_precharge_gap (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .load     (cas_release),
    .load_val (gap_val),
    .done     (gap_done)
  );

  dps_refresh_tick u_refresh (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .period  (cfg_refresh_period),
    .tick_r  (refresh_tick)
  );

  always_comb begin
    state_nxt = state_r;
    ph_nxt    = ph_r;
    acc_start = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_OPEN;
          ph_nxt    = '0;
        end
      end
      ST_OPEN: begin
        if (ph_r == PH_W'(ROW_SETUP_Q) && !gap_done) begin
          ph_nxt = ph_r;
        end else if (ph_r == PH_W'(OPEN_END_Q)) begin
          state_nxt = ST_ACCESS;
          ph_nxt    = PH_W'(1);
          acc_start = 1'b1;
        end else begin
          ph_nxt = ph_r + PH_W'(1);
        end
      end
      ST_ACCESS: begin
        if (ph_r == PH_W'(ACC_Q)) begin
          if (take && hit) begin
            ph_nxt    = PH_W'(1);
            acc_start = 1'b1;
          end else if (take || page_close_req) begin
            state_nxt = ST_CLOSE;
          end else begin
            state_nxt = ST_PAGE;
          end
        end else begin
          ph_nxt = ph_r + PH_W'(1);
        end
      end
      ST_PAGE: begin
        if (take && hit) begin
          state_nxt = ST_ACCESS;
          ph_nxt    = PH_W'(1);
          acc_start = 1'b1;
        end else if (take || page_close_req) begin
          state_nxt = ST_CLOSE;
        end
      end
      ST_CLOSE: begin
        if (hold_done) begin
          state_nxt = pend_r ? ST_OPEN : ST_IDLE;
          ph_nxt    = '0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        ph_nxt    = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      ph_r    <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      ph_r    <= ph_nxt;
    end
  end

  // Ready only where the next edge may start or queue an access
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_ready_r <= 1'b0;
    end else if (ce) begin
      req_ready_r <= cfg_ok && !(take && !hit && state_r != ST_IDLE) &&
                     ((state_nxt == ST_IDLE) || (state_nxt == ST_PAGE) ||
                      (state_nxt == ST_ACCESS && ph_nxt == PH_W'(ACC_Q)));
    end
  end

  // Request latch and pending row miss
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_row_r   <= '0;
      cur_col_r   <= '0;
      cur_wdata_r <= '0;
      cur_write_r <= 1'b0;
      pend_r      <= 1'b0;
    end else if (ce) begin
      if (take) begin
        cur_row_r   <= req_row;
        cur_col_r   <= req_col;
        cur_wdata_r <= req_wdata;
        cur_write_r <= req_write;
      end
      if (take && !hit && (state_r == ST_ACCESS || state_r == ST_PAGE)) begin
        pend_r <= 1'b1;
      end else if (state_r == ST_CLOSE && hold_done) begin
        pend_r <= 1'b0;
      end
    end
  end

  // Open row and address pins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      row_r  <= '0;
      addr_r <= '0;
    end else if (ce) begin
      if (state_r == ST_OPEN && ph_r == '0) begin
        row_r  <= cur_row_r;
        addr_r <= cur_row_r;
      end else if (acc_start) begin
        addr_r <= src_col;
      end
    end
  end

  // Row strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ras_n_r <= 1'b1;
    end else if (ce) begin
      if (state_r == ST_OPEN && ph_r == PH_W'(ROW_SETUP_Q) && gap_done) begin
        ras_n_r <= 1'b0;
      end else if (state_r == ST_CLOSE && hold_done) begin
        ras_n_r <= 1'b1;
      end
    end
  end

  // Column strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cas_n_r <= 1'b1;
    end else if (ce) begin
      if (state_r == ST_ACCESS && ph_r == PH_W'(CAS_ON_Q)) begin
        cas_n_r <= 1'b0;
      end else if (cas_release) begin
        cas_n_r <= 1'b1;
      end
    end
  end

  // Read and write strobes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
    end else if (ce) begin
      if (acc_start) begin
        wr_n_r <= !src_write;
        rd_n_r <= src_write;
      end else if (state_r == ST_ACCESS) begin
        if (ph_r == PH_W'(WR_OFF_Q)) begin
          wr_n_r <= 1'b1;
        end
        if (ph_r == PH_W'(RD_OFF_Q)) begin
          rd_n_r <= 1'b1;
        end
      end
    end
  end

  // Write data bus
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dq_o_r  <= '0;
      dq_oe_r <= 1'b0;
    end else if (ce) begin
      if (acc_start) begin
        dq_o_r <= src_wdata;
      end
      if (state_r == ST_ACCESS && cur_write_r) begin
        if (ph_r == PH_W'(DQ_ON_Q)) begin
          dq_oe_r <= 1'b1;
        end else if (ph_r == PH_W'(DQ_OFF_Q)) begin
          dq_oe_r <= 1'b0;
        end
      end
    end
  end

  // Read capture on the column release edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= '0;
    end else if (ce) begin
      rsp_valid_r <= 1'b0;
      if (state_r == ST_ACCESS && !cur_write_r && ph_r == PH_W'(CAPTURE_Q)) begin
        rsp_valid_r <= 1'b1;
        rsp_rdata_r <= dram_dq_i;
      end
    end
  end

  // Configuration status and refresh request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_bad_r     <= 1'b0;
      refresh_due_r <= 1'b0;
    end else if (ce) begin
      cfg_bad_r     <= !cfg_ok;
      refresh_due_r <= refresh_tick;
    end
  end

  assign req_ready   = req_ready_r;
  assign rsp_valid   = rsp_valid_r;
  assign rsp_rdata   = rsp_rdata_r;
  assign cfg_bad     = cfg_bad_r;
  assign refresh_due = refresh_due_r;
  assign dram_ras_n  = ras_n_r;
  assign dram_cas_n  = cas_n_r;
  assign dram_rd_n   = rd_n_r;
  assign dram_wr_n   = wr_n_r;
  assign dram_addr   = addr_r;
  assign dram_dq_o   = dq_o_r;
  assign dram_dq_oe  = dq_oe_r;

endmodule // dps_sequencer

// ===== rtl/dps_pkg.sv
package dps_pkg;

  // Timebase: the internal period is four ref_clk cycles, one quarter each
  localparam int CLK_PERIOD_NS = 100;
  localparam int TC_NS         = 400;
  localparam int Q_PER_TC      = TC_NS / CLK_PERIOD_NS;

  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 24;
  localparam int PH_W      = 5;
  localparam int TMR_W     = 6;
  localparam int REFRESH_W = 16;

  localparam logic [3:0] SUPPORTED_WS = 4'h3;
  localparam logic [1:0] OOP_WAIT_A   = 2'h2;
  localparam logic [1:0] OOP_WAIT_B   = 2'h3;

  // Figures in hundredths of an internal period
  localparam int SAME_DIR_CYC_X100   = 400;
  localparam int MIXED_CYC_X100      = 350;
  localparam int CAS_WIDTH_X100      = 200;
  localparam int CAS_OFF_X100        = 150;
  localparam int COL_SETUP_X100      = 100;
  localparam int COL_HOLD_X100       = 250;
  localparam int RAS_AFT_CASOFF_X100 = 450;
  localparam int GAP_A_X100          = 475;
  localparam int GAP_B_X100          = 675;
  localparam int WR_TO_CAS_X100      = 125;
  localparam int WR_WIDTH_X100       = 350;
  localparam int WR_BEF_CASOFF_X100  = 325;
  localparam int DATA_HOLD_X100      = 250;
  localparam int DQ_ON_X100          = 75;

  function automatic int min_q(input int x100);
    min_q = (x100 * Q_PER_TC + 99) / 100;
  endfunction

  function automatic int max_q(input int x100);
    max_q = (x100 * Q_PER_TC) / 100;
  endfunction

  // Event positions within one column access, in quarters from its start; row hold and gaps count from column release
  localparam int CAS_ON_Q   = min_q(WR_TO_CAS_X100);
  localparam int DQ_ON_Q    = max_q(DQ_ON_X100);
  localparam int CAS_OFF_Q  = min_q(WR_BEF_CASOFF_X100);
  localparam int WR_OFF_Q   = min_q(WR_WIDTH_X100);
  localparam int DQ_OFF_Q   = CAS_ON_Q + min_q(DATA_HOLD_X100);
  localparam int RD_OFF_Q   = CAS_OFF_Q + 1;
  localparam int CAPTURE_Q  = CAS_OFF_Q;
  localparam int ACC_Q      = min_q(SAME_DIR_CYC_X100);
  localparam int RAS_HOLD_Q = min_q(RAS_AFT_CASOFF_X100);
  localparam int GAP_A_Q    = min_q(GAP_A_X100);
  localparam int GAP_B_Q    = min_q(GAP_B_X100);

  // Row opening: address setup before row strobe, then row-to-column delay
  localparam int ROW_SETUP_Q = 2;
  localparam int OPEN_END_Q  = ROW_SETUP_Q + 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPEN,
    ST_ACCESS,
    ST_PAGE,
    ST_CLOSE
  } dps_state_e;

endpackage

// ===== rtl/dps_down_timer.sv
`timescale 1ns/1ns
module dps_down_timer
  import dps_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             load,
  input  wire logic [TMR_W-1:0] load_val,
  output logic                  done
);

  logic [TMR_W-1:0] cnt_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (load) begin
        cnt_r <= load_val;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - TMR_W'(1);
      end
    end
  end

  assign done = (cnt_r == '0);

endmodule // dps_down_timer

// ===== rtl/dps_refresh_tick.sv
`timescale 1ns/1ns
module dps_refresh_tick
  import dps_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic [REFRESH_W-1:0] period,
  output logic                      tick_r
);

  logic [REFRESH_W-1:0] cnt_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (ce) begin
      // Zero period disables the tick
      if (period == '0) begin
        cnt_r  <= '0;
        tick_r <= 1'b0;
      end else if (cnt_r >= period - REFRESH_W'(1)) begin
        cnt_r  <= '0;
        tick_r <= 1'b1;
      end else begin
        cnt_r  <= cnt_r + REFRESH_W'(1);
        tick_r <= 1'b0;
      end
    end
  end

endmodule // dps_refresh_tick

// ===== verif/dps_sequencer_properties.sv
`timescale 1ns/1ns
module dps_sequencer_chk
  import dps_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [1:0]        out_of_page_wait_select,
  input wire logic              dram_ras_n,
  input wire logic              dram_cas_n,
  input wire logic              dram_rd_n,
  input wire logic              dram_wr_n,
  input wire logic [ADDR_W-1:0] dram_addr,
  input wire logic              dram_dq_oe
);
  logic [5:0] cas_hi_r;
  logic [5:0] since_fall_r;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Cycles with column strobe high, saturating
  always_ff @(posedge ref_clk) begin
    if (rst) cas_hi_r <= 6'h3f;
    else if (!dram_cas_n) cas_hi_r <= 6'h00;
    else if (cas_hi_r != 6'h3f) cas_hi_r <= cas_hi_r + 6'h01;
  end

  // Cycles since the last column strobe fall
  always_ff @(posedge ref_clk) begin
    if (rst) since_fall_r <= 6'h3f;
    else if (!dram_cas_n && cas_hi_r != 6'h00) since_fall_r <= 6'h01;
    else if (since_fall_r != 6'h3f) since_fall_r <= since_fall_r + 6'h01;
  end

  cas_width_a: assert property ($fell(dram_cas_n) |-> !dram_cas_n[*8])
    else $error("column strobe pulse too short");
  cas_off_a: assert property ($rose(dram_cas_n) |-> dram_cas_n[*6])
    else $error("column strobe high time too short");
  acc_space_a: assert property ($fell(dram_cas_n) |-> since_fall_r >= 6'h10)
    else $error("page accesses too close");
  col_setup_a: assert property ($fell(dram_cas_n) |-> dram_addr == $past(dram_addr, 4))
    else $error("column address late");
  col_hold_a: assert property ($fell(dram_cas_n) |=> $stable(dram_addr)[*8] ##1
    $stable(dram_addr)[*2]) else $error("column address hold short");
  wr_lead_a: assert property ($fell(dram_cas_n) && !dram_wr_n |->
    !$past(dram_wr_n, 5) && dram_dq_oe) else $error("write strobe or data late");
  rd_lead_a: assert property ($fell(dram_cas_n) && !dram_rd_n |->
    dram_wr_n && $past(dram_wr_n, 5)) else $error("write strobe low on read");
  wr_width_a: assert property ($fell(dram_wr_n) |->
    !dram_wr_n[*7] ##1 !dram_wr_n[*7]) else $error("write strobe too short");
  rd_release_a: assert property ($rose(dram_rd_n) |-> dram_cas_n && $past(dram_cas_n))
    else $error("read strobe released before column strobe");
  dq_on_a: assert property ($rose(dram_dq_oe) |-> !$past(dram_wr_n, 3))
    else $error("data bus driven too early");
  dq_off_a: assert property ($rose(dram_wr_n) |=> !dram_dq_oe)
    else $error("data bus not released");
  ras_hold_a: assert property ($rose(dram_ras_n) |-> cas_hi_r >= 6'h12)
    else $error("row strobe released too early");
  ras_gap_a: assert property ($fell(dram_ras_n) && out_of_page_wait_select[1] |->
    cas_hi_r >= (out_of_page_wait_select[0] ? 6'h1b : 6'h13)) else $error("precharge gap short");
  page_row_a: assert property ($fell(dram_cas_n) |-> !dram_ras_n)
    else $error("column strobe without open row");
  wr_reassert_a: assert property ($fell(dram_wr_n) |-> cas_hi_r >= 6'h03)
    else $error("write strobe back too soon after column release");
endmodule // dps_sequencer_chk

bind dps_sequencer dps_sequencer_chk u_chk (
  .ref_clk(ref_clk), .rst(rst), .out_of_page_wait_select(out_of_page_wait_select),
  .dram_ras_n(dram_ras_n), .dram_cas_n(dram_cas_n), .dram_rd_n(dram_rd_n),
  .dram_wr_n(dram_wr_n), .dram_addr(dram_addr), .dram_dq_oe(dram_dq_oe)
);

// ===== verif/dps_dram_model.sv
`timescale 1ns/1ns
module dps_dram_model
  import dps_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              slow,
  input  wire logic              dram_ras_n,
  input  wire logic              dram_cas_n,
  input  wire logic              dram_rd_n,
  input  wire logic              dram_wr_n,
  input  wire logic [ADDR_W-1:0] dram_addr,
  input  wire logic [DATA_W-1:0] dram_dq_o,
  input  wire logic              dram_dq_oe,
  output logic      [DATA_W-1:0] dram_dq_i
);
  logic [DATA_W-1:0] mem[int];
  logic [ADDR_W-1:0] row_r;
  logic              ras_q, cas_q;
  int                wait_c;

  initial begin
    ras_q = 1'b1;
    cas_q = 1'b1;
    wait_c = 0;
    dram_dq_i = '0;
  end

  always @(posedge ref_clk) begin
    ras_q <= dram_ras_n;
    cas_q <= dram_cas_n;
    if (ras_q && !dram_ras_n) row_r <= dram_addr;
    if (cas_q && !dram_cas_n && !dram_ras_n) begin
      // Bus not driven stores garbage
      if (!dram_wr_n) mem[{row_r, dram_addr}] = dram_dq_oe ? dram_dq_o : ~dram_dq_o;
      // Slow part answers one cycle after the fast part, four cycles before read capture
      wait_c <= slow ? 2 : 1;
    end else if (wait_c > 0) wait_c <= wait_c - 1;
    // Outside the valid window the bus toggles every cycle
    if (!cas_q && !dram_cas_n && !dram_rd_n && wait_c == 0) begin
      dram_dq_i <= mem[{row_r, dram_addr}];
    end else dram_dq_i <= ~dram_dq_i;
  end
endmodule // dps_dram_model

// ===== verif/dps_sequencer_test.sv
`timescale 1ns/1ns
module dps_sequencer_test;
  import dps_pkg::*;
  logic              ref_clk, rst, ce, page_close_req, req_valid, req_write, slow;
  logic              req_ready, rsp_valid, cfg_bad, refresh_due;
  logic              dram_ras_n, dram_cas_n, dram_rd_n, dram_wr_n, dram_dq_oe;
  logic [3:0]        cfg_page_wait_states;
  logic [1:0]        out_of_page_wait_select;
  logic [15:0]       refresh_period, lfsr_r;
  logic [ADDR_W-1:0] req_row, req_col, dram_addr;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, dram_dq_o, dram_dq_i;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] shadow[int];
  int                errors, total_checks, n;

  dps_sequencer i_dut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .cfg_page_wait_states(cfg_page_wait_states),
    .cfg_refresh_period(refresh_period), .out_of_page_wait_select(out_of_page_wait_select),
    .page_close_req(page_close_req), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .cfg_bad(cfg_bad),
    .refresh_due(refresh_due), .dram_ras_n(dram_ras_n), .dram_cas_n(dram_cas_n),
    .dram_rd_n(dram_rd_n), .dram_wr_n(dram_wr_n), .dram_addr(dram_addr),
    .dram_dq_o(dram_dq_o), .dram_dq_oe(dram_dq_oe), .dram_dq_i(dram_dq_i)
  );

  dps_dram_model i_mem (
    .ref_clk(ref_clk), .slow(slow), .dram_ras_n(dram_ras_n), .dram_cas_n(dram_cas_n),
    .dram_rd_n(dram_rd_n), .dram_wr_n(dram_wr_n), .dram_addr(dram_addr),
    .dram_dq_o(dram_dq_o), .dram_dq_oe(dram_dq_oe), .dram_dq_i(dram_dq_i)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task tick(input int k);
    repeat (k) @(posedge ref_clk);
    #10;
  endtask

  // Leaves req_valid high; caller lowers it
  task acc(input logic w, input logic [11:0] r, input logic [11:0] c,
           input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    req_write = w;
    req_row = r;
    req_col = c;
    req_wdata = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
    if (k >= 400) begin
      errors++;
      stop_test();
    end
    tick(1);
    if (w) shadow[{r, c}] = d;
    else exp_q.push_back(shadow[{r, c}]);
  endtask

  task drain;
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 300) begin
      tick(1);
      k++;
    end
    if (k >= 300) begin
      errors++;
      stop_test();
    end
  endtask

  // Read results against the oldest note
  always @(posedge ref_clk) begin
    #20;
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check({23'h0, rsp_valid}, 24'h000000);
      else check(rsp_rdata, exp_q.pop_front());
    end
  end

  initial begin
    {rst, ce, page_close_req, req_valid, req_write, slow} = 6'h30;
    cfg_page_wait_states = 4'h3;
    out_of_page_wait_select = 2'h0;
    refresh_period = 16'h0000;
    {req_row, req_col, req_wdata} = '0;
    lfsr_r = 16'h002e;
    errors = 0;
    total_checks = 0;
    repeat (3) @(posedge ref_clk);
    #10;
    rst = 1'b0;
    tick(2);
    cfg_page_wait_states = 4'h5;
    tick(3);
    check({22'h0, cfg_bad, req_ready}, 24'h000002);
    cfg_page_wait_states = 4'h3;
    tick(3);
    $display("test config done");
    for (int i = 0; i < 20; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      acc(i < 4 ? 1'b1 : lfsr_r[0], 12'h005, {10'h000, i < 4 ? i[1:0] : lfsr_r[2:1]},
          {lfsr_r[7:0], lfsr_r});
    end
    req_valid = 1'b0;
    drain();
    $display("test page done");
    for (int s = 0; s < 4; s++) begin
      out_of_page_wait_select = s[1:0];
      lfsr_r = lfsr_next(lfsr_r);
      acc(1'b1, 12'h100 + s[11:0], 12'h00a, {lfsr_r, lfsr_r[15:8]});
      acc(1'b0, 12'h100 + s[11:0], 12'h00a, '0);
    end
    req_valid = 1'b0;
    drain();
    $display("test rows done");
    slow = 1'b1;
    for (int i = 0; i < 3; i++) acc(1'b0, 12'h005, i[11:0], '0);
    req_valid = 1'b0;
    drain();
    slow = 1'b0;
    $display("test slow memory done");
    page_close_req = 1'b1;
    n = 0;
    while (dram_ras_n !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check({23'h0, dram_ras_n}, 24'h000001);
    page_close_req = 1'b0;
    acc(1'b0, 12'h103, 12'h00a, '0);
    req_valid = 1'b0;
    drain();
    $display("test close done");
    refresh_period = 16'h0014;
    n = 0;
    while (refresh_due !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    n = 0;
    // Frozen clock enable holds the pulse and stalls the interval
    ce = 1'b0;
    tick(10);
    check({23'h0, refresh_due}, 24'h000001);
    ce = 1'b1;
    tick(1);
    while (refresh_due !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check(24'(n + 1), 24'h000014);
    $display("test refresh done");
    stop_test();
  end
endmodule // dps_sequencer_test
